/* dv/bsc_host_model.sv */
// partner model: processor and cache controller pins, plus the array read source
module bsc_host_model
    import bsc_pkg::*;
(
    input  wire bsc_array_req_t   array_req,
    output bsc_cycle_ctl_t        cyc,
    output bsc_write_ctl_t        wctl,
    output logic [BSC_ADDR_W-1:0] addr,
    output logic                  output_enable_n,
    output logic [BSC_DATA_W-1:0] dq_in,
    output logic                  sleep_request,
    output logic                  sleep_request_driven,
    output logic                  burst_order_sel,
    output logic                  burst_order_sel_driven,
    output logic [BSC_DATA_W-1:0] array_rdata
);
    // ==========================================================
    // array source: data folds address bits 15:0, so a wrong address in those bits shows
    assign array_rdata = {array_req.addr[15:0], ~array_req.addr[15:0]};

    // ==========================================================
    // pin drivers, called by the bench just after a falling edge
    task automatic drive(input bsc_cycle_ctl_t c, input bsc_write_ctl_t w, input logic [BSC_ADDR_W-1:0] a,
                         input logic oe_n, input logic [BSC_DATA_W-1:0] d);
        cyc             = c;
        wctl            = w;
        addr            = a;
        output_enable_n = oe_n;
        dq_in           = d;
    endtask

    // selects, strobes and output enable inactive; sleep is left alone here and only set_sleep raises it
    task automatic idle();
        cyc             = 6'h2f;
        wctl            = 6'h3f;
        addr            = ~addr;
        output_enable_n = 1'b1;
        dq_in           = ~dq_in;  // released data never repeats its last value
    endtask

    task automatic set_sleep(input logic s, input logic drv);
        sleep_request        = s;
        sleep_request_driven = drv;
    endtask

    task automatic set_order(input logic s, input logic drv);
        burst_order_sel        = s;
        burst_order_sel_driven = drv;
    endtask

    task automatic set_oe(input logic oe_n);
        output_enable_n = oe_n;
    endtask

    initial
    begin
        addr  = '0;
        dq_in = '0;
        idle();
        set_sleep(1'b0, 1'b1);
        set_order(1'b1, 1'b1);
    end
endmodule

/* dv/burst_sram_cycle_control_tb.sv */
// self-checking bench for the burst sram cycle control
module burst_sram_cycle_control_tb
    import bsc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    // ==========================================================
    // signals
    localparam bsc_cycle_ctl_t cy_pbeg = 6'h13;
    localparam bsc_cycle_ctl_t cy_cbeg = 6'h15;
    localparam bsc_cycle_ctl_t cy_cont = 6'h2e;
    localparam bsc_cycle_ctl_t cy_susp = 6'h2f;
    localparam bsc_write_ctl_t wr_none = 6'h3f;
    localparam bsc_write_ctl_t wr_all  = 6'h1f;
    logic                  clk_sys;
    logic                  sys_rst;
    logic                  sleep_request;
    logic                  sleep_request_driven;
    logic                  burst_order_sel;
    logic                  burst_order_sel_driven;
    bsc_cycle_ctl_t        cyc;
    bsc_write_ctl_t        wctl;
    logic [BSC_ADDR_W-1:0] addr;
    logic [BSC_ADDR_W-1:0] base;
    logic                  output_enable_n;
    logic [BSC_DATA_W-1:0] dq_in;
    logic [BSC_DATA_W-1:0] dq_out;
    logic                  dq_oe;
    logic [BSC_DATA_W-1:0] array_rdata;
    bsc_array_req_t        array_req;
    logic                  low_power;
    int                    mismatches;
    int                    checks;
    int                    cycles;

    bsc_host_model host_u (.array_req(array_req), .cyc(cyc), .wctl(wctl), .addr(addr),
        .output_enable_n(output_enable_n), .dq_in(dq_in), .sleep_request(sleep_request),
        .sleep_request_driven(sleep_request_driven), .burst_order_sel(burst_order_sel),
        .burst_order_sel_driven(burst_order_sel_driven), .array_rdata(array_rdata));

    bsc_top dut_u (.clk_sys(clk_sys), .sys_rst(sys_rst), .sleep_request(sleep_request),
        .sleep_request_driven(sleep_request_driven), .burst_order_sel(burst_order_sel),
        .burst_order_sel_driven(burst_order_sel_driven), .cyc(cyc), .wctl(wctl), .addr(addr),
        .output_enable_n(output_enable_n), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
        .array_rdata(array_rdata), .array_req(array_req), .low_power(low_power));

    // ==========================================================
    // clock, timeout and common tasks
    initial clk_sys = 1'b0;
    always #25 clk_sys = ~clk_sys;

    // a hang shows as a cycle count far past the hundred or so the tests need
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            mismatches++;
            $display("MISMATCH at %0t: run timed out", $time);
            close_out();
        end
    end

    task automatic close_out();
        $display("counts: %0d checks, %0d mismatches", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic check(input logic [63:0] seen, input logic [63:0] want, input string what);
        checks++;
        if (seen !== want)
        begin
            mismatches++;
            $display("MISMATCH at %0t: %s seen %h want %h", $time, what, seen, want);
        end
    endtask

    function automatic logic [BSC_DATA_W-1:0] data_of(input logic [BSC_ADDR_W-1:0] a);
        return {a[15:0] ^ 16'h5a5a, a[15:0]};
    endfunction

    // one cycle: drive, let the taking edge pass, judge the registered answer
    task automatic step(input bsc_cycle_ctl_t c, input bsc_write_ctl_t w, input logic [BSC_ADDR_W-1:0] a,
                        input logic oe_n, input logic rd, input logic wr, input logic [1:0] lsb,
                        input logic [3:0] be);
        logic [BSC_ADDR_W-1:0] exp_a;
        exp_a = {base[BSC_ADDR_W-1:2], lsb};
        host_u.drive(c, w, a, oe_n, data_of(a));
        @(negedge clk_sys);
        check(array_req.read, rd, "read strobe");
        check(array_req.write, wr, "write strobe");
        check(array_req.byte_en, be, "byte enables");
        check(dq_oe, rd & ~oe_n, "data drive");
        if (rd | wr)
            check(array_req.addr, exp_a, "array address");
        if (rd)
            check(dq_out, {exp_a[15:0], ~exp_a[15:0]}, "read data");
        if (wr)
            check(array_req.wdata, data_of(a), "write data");
    endtask

    // ==========================================================
    // scenarios
    task automatic t_order();
        logic [1:0] exp;
        for (int m = 0; m < 3; m++)
        begin
            host_u.set_order(m[0], m != 2);  // third pass leaves the select unconnected
            for (int s = 0; s < 4; s++)
            begin
                base = {15'h1b3c, s[1:0]};
                step(cy_pbeg, wr_none, base, 1'b0, 1'b1, 1'b0, base[1:0], 4'h0);
                for (int n = 1; n < 4; n++)
                begin
                    exp = (m == 0) ? base[1:0] + n[1:0] : base[1:0] ^ n[1:0];
                    step(cy_cont, wr_none, ~base, 1'b0, 1'b1, 1'b0, exp, 4'h0);
                end
            end
        end
        $display("test burst order done");
    endtask

    task automatic t_writes();
        logic wr;
        base = 17'h0c0d2;
        for (int l = 0; l < 16; l++)
        begin
            wr = (l != 15);
            step(cy_cbeg, {2'b10, l[3:0]}, base, 1'b1, ~wr, wr, 2'h2, wr ? ~l[3:0] : 4'h0);
        end
        step(cy_cbeg, wr_all, base, 1'b1, 1'b0, 1'b1, 2'h2, 4'hf);
        step(cy_cbeg, 6'h30, base, 1'b1, 1'b1, 1'b0, 2'h2, 4'h0);
        $display("test write decode done");
    endtask

    task automatic t_burst_mix();
        base = 17'h12340;
        step(cy_pbeg, wr_all, base, 1'b1, 1'b1, 1'b0, 2'h0, 4'h0);
        step(cy_cont, wr_all, ~base, 1'b0, 1'b0, 1'b1, 2'h1, 4'hf);
        step(cy_susp, 6'h2e, base, 1'b1, 1'b0, 1'b1, 2'h1, 4'h1);
        step(cy_susp, wr_none, base, 1'b0, 1'b1, 1'b0, 2'h1, 4'h0);
        step(6'h2a, wr_none, 17'h1ffff, 1'b0, 1'b1, 1'b0, 2'h2, 4'h0);
        host_u.set_oe(1'b1);
        #1 check(dq_oe, 1'b0, "enable off");
        host_u.set_oe(1'b0);
        #1 check(dq_oe, 1'b1, "enable on");
        @(negedge clk_sys);
        $display("test burst mix done");
    endtask

    task automatic t_deselect();
        bsc_cycle_ctl_t pats [4] = '{6'h03, 6'h1b, 6'h2d, 6'h05};
        base = 17'h0aa55;
        foreach (pats[i])
        begin
            step(cy_pbeg, wr_none, base, 1'b0, 1'b1, 1'b0, 2'h1, 4'h0);
            step(pats[i], wr_none, base, 1'b0, 1'b0, 1'b0, 2'h1, 4'h0);
            step(cy_susp, wr_none, base, 1'b0, 1'b0, 1'b0, 2'h1, 4'h0);
        end
        $display("test deselect done");
    endtask

    task automatic t_sleep();
        int n;
        step(6'h2d, wr_none, base, 1'b1, 1'b0, 1'b0, 2'h0, 4'h0);
        host_u.set_sleep(1'b1, 1'b1);
        step(cy_pbeg, wr_none, base, 1'b0, 1'b0, 1'b0, 2'h1, 4'h0);
        host_u.idle();
        check(low_power, 1'b0, "asleep too early");
        n = 0;
        while (low_power !== 1'b1 && n < 8)
        begin
            @(negedge clk_sys);
            n++;
        end
        check(n >= 2 && n <= 6, 1'b1, "sleep entry time");
        host_u.set_sleep(1'b0, 1'b1);
        repeat (2) @(negedge clk_sys);  // recovery with pins idle
        n = 0;
        while (low_power !== 1'b0 && n < 8)
        begin
            @(negedge clk_sys);
            n++;
        end
        check(low_power, 1'b0, "sleep exit");
        repeat (3) @(negedge clk_sys);
        base = 17'h00a53;
        step(cy_pbeg, wr_none, base, 1'b0, 1'b1, 1'b0, 2'h3, 4'h0);
        host_u.set_sleep(1'b1, 1'b0);
        repeat (6) @(negedge clk_sys);
        step(cy_pbeg, wr_none, base, 1'b0, 1'b1, 1'b0, 2'h3, 4'h0);
        check(low_power, 1'b0, "unconnected sleep pin");
        host_u.set_sleep(1'b0, 1'b1);
        $display("test sleep done");
    endtask

    // ==========================================================
    // main sequence
    initial
    begin
        mismatches = 0;
        checks     = 0;
        cycles     = 0;
        base       = '0;
        sys_rst    = 1'b1;
        repeat (12) @(negedge clk_sys);
        check(array_req, BSC_REQ_RST, "request at reset");
        check({low_power, dq_oe}, 2'h0, "flags at reset");
        sys_rst = 1'b0;
        t_order();
        t_writes();
        t_burst_mix();
        t_deselect();
        t_sleep();
        close_out();
    end
endmodule

/* hdl/bsc_burst_ctr.sv */
// two bit wraparound burst counter, linear or interleaved
module bsc_burst_ctr
    import bsc_pkg::*;
(
    input  wire logic                 clk_sys,
    input  wire logic                 sys_rst,
    input  wire logic                 load,
    input  wire logic                 step,
    input  wire logic                 order_interleaved,
    input  wire logic [BSC_LSB_W-1:0] start,
    output logic      [BSC_LSB_W-1:0] access_lsb
);

    logic [BSC_LSB_W-1:0] start_q;
    logic [BSC_LSB_W-1:0] count_q;
    logic                 mode_q;
    logic [BSC_LSB_W-1:0] next_count;

    // ==========================================================
    // address of the access taken at this edge
    always_comb
    begin
        next_count = step ? BSC_LSB_W'(count_q + 2'h1) : count_q;
        if (load)
            access_lsb = start;
        else if (mode_q)
            access_lsb = start_q ^ next_count;
        else
            access_lsb = BSC_LSB_W'(start_q + next_count);
    end

    // order is caught with the start so a mid-burst change cannot scramble it
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            start_q <= BSC_LSB_RST;
            count_q <= BSC_LSB_RST;
            mode_q  <= BSC_MODE_RST;
        end
        else if (load)
        begin
            start_q <= start;
            count_q <= BSC_LSB_RST;
            mode_q  <= order_interleaved;
        end
        else
        begin
            count_q <= next_count;
        end
    end

    lin_step_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (!load && step && !mode_q) |-> access_lsb == BSC_LSB_W'(start_q + count_q + 2'h1))
        else $error("linear burst step wrong");

endmodule

/* hdl/bsc_pkg.sv */
// shared constants and types for the burst sram cycle control
package bsc_pkg;

    // ==========================================================
    // widths
    localparam int BSC_ADDR_W  = 17;
    localparam int BSC_DATA_W  = 32;
    localparam int BSC_LANES   = 4;
    localparam int BSC_LSB_W   = 2;
    localparam int BSC_SCNT_W  = 2;

    // ==========================================================
    // timing, in ns and derived cycle counts at 20 mhz
    localparam int BSC_CLK_PERIOD_NS   = 50;
    localparam int BSC_SLEEP_ENTRY_NS  = 2 * BSC_CLK_PERIOD_NS;
    localparam int BSC_SLEEP_RECOV_NS  = 2 * BSC_CLK_PERIOD_NS;
    localparam int BSC_SLEEP_ENTRY_CYC = (BSC_SLEEP_ENTRY_NS / BSC_CLK_PERIOD_NS < 1) ? 1 :
                                         BSC_SLEEP_ENTRY_NS / BSC_CLK_PERIOD_NS;
    localparam int BSC_SLEEP_RECOV_CYC = (BSC_SLEEP_RECOV_NS + BSC_CLK_PERIOD_NS - 1) / BSC_CLK_PERIOD_NS;
    localparam logic [BSC_SCNT_W-1:0] BSC_ENTRY_LAST = BSC_SCNT_W'(BSC_SLEEP_ENTRY_CYC - 1);
    localparam logic [BSC_SCNT_W-1:0] BSC_RECOV_LAST = BSC_SCNT_W'(BSC_SLEEP_RECOV_CYC - 1);

    // ==========================================================
    // reset values
    localparam logic [BSC_LSB_W-1:0]  BSC_LSB_RST  = 2'h0;
    localparam logic [BSC_SCNT_W-1:0] BSC_SCNT_RST = 2'h0;
    localparam logic                  BSC_MODE_RST = 1'b1;

    // ==========================================================
    // sleep state machine
    typedef enum logic [1:0] {
        BSC_ST_ACTIVE = 2'b00,
        BSC_ST_ENTER  = 2'b01,
        BSC_ST_ASLEEP = 2'b10,
        BSC_ST_WAKE   = 2'b11
    } bsc_state_t;

    // ==========================================================
    // carriers
    typedef struct packed {
        logic chip_select_low_first;
        logic chip_select_high_second;
        logic chip_select_low_third;
        logic processor_addr_strobe_n;
        logic controller_addr_strobe_n;
        logic burst_advance_n;
    } bsc_cycle_ctl_t;

    typedef struct packed {
        logic                 global_write_n;
        logic                 byte_write_enable_n;
        logic [BSC_LANES-1:0] byte_lane_select_n;
    } bsc_write_ctl_t;

    typedef struct packed {
        logic [BSC_ADDR_W-1:0] addr;
        logic                  read;
        logic                  write;
        logic [BSC_LANES-1:0]  byte_en;
        logic [BSC_DATA_W-1:0] wdata;
    } bsc_array_req_t;

    localparam bsc_array_req_t BSC_REQ_RST = '0;

endpackage

/* hdl/bsc_top.sv */
// cycle control of a flow-through burst cache sram, memory side
// ==========================================================
module bsc_top
    import bsc_pkg::*;
(
    input  wire logic                  clk_sys,
    input  wire logic                  sys_rst,
    input  wire logic                  sleep_request,
    input  wire logic                  sleep_request_driven,
    input  wire logic                  burst_order_sel,
    input  wire logic                  burst_order_sel_driven,
    input  wire bsc_cycle_ctl_t        cyc,
    input  wire bsc_write_ctl_t        wctl,
    input  wire logic [BSC_ADDR_W-1:0] addr,
    input  wire logic                  output_enable_n,
    input  wire logic [BSC_DATA_W-1:0] dq_in,
    output logic      [BSC_DATA_W-1:0] dq_out,
    output logic                       dq_oe,
    input  wire logic [BSC_DATA_W-1:0] array_rdata,
    output bsc_array_req_t             array_req,
    output logic                       low_power
);

    // ==========================================================
    // pin defaults and sleep synchroniser
    logic       sleep_level;
    logic       order_interleaved;
    logic       sleep_meta;
    logic       sleep_sync;

    assign sleep_level       = sleep_request_driven & sleep_request;
    assign order_interleaved = burst_order_sel_driven ? burst_order_sel : 1'b1;

    // sleep arrives with no relation to the clock, so it is synchronised first
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            sleep_meta <= 1'b0;
            sleep_sync <= 1'b0;
        end
        else
        begin
            sleep_meta <= sleep_level;
            sleep_sync <= sleep_meta;
        end
    end

    // ==========================================================
    // sleep state machine
    bsc_state_t            state;
    bsc_state_t            next_state;
    logic [BSC_SCNT_W-1:0] sleep_cnt;
    logic [BSC_SCNT_W-1:0] next_sleep_cnt;

    always_comb
    begin
        next_state     = state;
        next_sleep_cnt = BSC_SCNT_RST;
        case (state)
            BSC_ST_ACTIVE:
            begin
                if (sleep_sync)
                    next_state = BSC_ST_ENTER;
            end
            BSC_ST_ENTER:
            begin
                if (!sleep_sync)
                    next_state = BSC_ST_WAKE;
                else if (sleep_cnt == BSC_ENTRY_LAST)
                    next_state = BSC_ST_ASLEEP;
                else
                    next_sleep_cnt = BSC_SCNT_W'(sleep_cnt + 2'h1);
            end
            BSC_ST_ASLEEP:
            begin
                if (!sleep_sync)
                    next_state = BSC_ST_WAKE;
            end
            BSC_ST_WAKE:
            begin
                if (sleep_sync)
                    next_state = BSC_ST_ENTER;
                else if (sleep_cnt == BSC_RECOV_LAST)
                    next_state = BSC_ST_ACTIVE;
                else
                    next_sleep_cnt = BSC_SCNT_W'(sleep_cnt + 2'h1);
            end
            default:
            begin
                next_state = BSC_ST_ACTIVE;
            end
        endcase
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            state     <= BSC_ST_ACTIVE;
            sleep_cnt <= BSC_SCNT_RST;
        end
        else
        begin
            state     <= next_state;
            sleep_cnt <= next_sleep_cnt;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            low_power <= 1'b0;
        else
            low_power <= (next_state == BSC_ST_ASLEEP);
    end

    // ==========================================================
    // cycle decode
    logic                 accept;
    logic                 chips_ok;
    logic                 proc_strobe;
    logic                 begin_burst;
    logic                 deselect;
    logic                 access;
    logic                 step;
    logic                 is_write;
    logic                 burst_live;
    logic                 write_req;
    logic [BSC_LANES-1:0] byte_en;
    logic [BSC_LSB_W-1:0] access_lsb;

    // the raw level is used here too so inputs are ignored before the sync settles
    assign accept      = (state == BSC_ST_ACTIVE) && !sleep_sync && !sleep_level;
    assign chips_ok    = !cyc.chip_select_low_first && cyc.chip_select_high_second &&
                         !cyc.chip_select_low_third;
    assign proc_strobe = !cyc.processor_addr_strobe_n && !cyc.chip_select_low_first;

    always_comb
    begin
        begin_burst = 1'b0;
        deselect    = 1'b0;
        access      = 1'b0;
        step        = 1'b0;
        is_write    = 1'b0;
        if (accept)
        begin
            if (proc_strobe)
            begin
                begin_burst = chips_ok;
                deselect    = !chips_ok;
                access      = chips_ok;
                is_write    = 1'b0;
            end
            else if (!cyc.controller_addr_strobe_n)
            begin
                begin_burst = chips_ok;
                deselect    = !chips_ok;
                access      = chips_ok;
                is_write    = chips_ok && write_req;
            end
            else if (burst_live)
            begin
                access   = 1'b1;
                step     = !cyc.burst_advance_n;
                is_write = write_req;
            end
        end
    end

    // a burst is dropped on deselect or on leaving the active state
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            burst_live <= 1'b0;
        else if (!accept || deselect)
            burst_live <= 1'b0;
        else if (begin_burst)
            burst_live <= 1'b1;
    end

    bsc_wr_decode u_wr_decode (
        .wctl      (wctl),
        .byte_en   (byte_en),
        .write_req (write_req)
    );

    bsc_burst_ctr u_burst_ctr (
        .clk_sys           (clk_sys),
        .sys_rst           (sys_rst),
        .load              (begin_burst),
        .step              (step),
        .order_interleaved (order_interleaved),
        .start             (addr[BSC_LSB_W-1:0]),
        .access_lsb        (access_lsb)
    );

    // ==========================================================
    // array request and data lines
    logic [BSC_ADDR_W-1:BSC_LSB_W] addr_hi;
    logic                          dq_drive;

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            addr_hi <= '0;
        else if (begin_burst)
            addr_hi <= addr[BSC_ADDR_W-1:BSC_LSB_W];
    end

    // write strobe is high for every write access taken, so it stays high across back-to-back burst writes; the array finishes it on its own
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            array_req <= BSC_REQ_RST;
        end
        else
        begin
            array_req.read    <= access && !is_write;
            array_req.write   <= access && is_write;
            array_req.byte_en <= (access && is_write) ? byte_en : '0;
            if (access)
            begin
                array_req.addr <= {begin_burst ? addr[BSC_ADDR_W-1:BSC_LSB_W] : addr_hi, access_lsb};
                array_req.wdata <= dq_in;
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            dq_drive <= 1'b0;
        else
            dq_drive <= access && !is_write;
    end

    // output enable is not sampled: it gates the driver directly
    assign dq_oe  = dq_drive && !output_enable_n && !sleep_level;
    assign dq_out = array_rdata;

    // ==========================================================
    // checks
    deselect_float_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (accept && !cyc.controller_addr_strobe_n && !chips_ok) |=>
            (!dq_drive && !array_req.read && !array_req.write))
        else $error("deselect did not float");

    proc_read_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (accept && proc_strobe && chips_ok) |=>
            (array_req.read && !array_req.write && array_req.addr == $past(addr)))
        else $error("processor begin not a read");

    ctrl_write_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (accept && cyc.processor_addr_strobe_n && !cyc.controller_addr_strobe_n && chips_ok && write_req) |=>
            (array_req.write && array_req.byte_en == $past(byte_en)))
        else $error("controller write begin missed");

    suspend_hold_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (accept && burst_live && cyc.controller_addr_strobe_n && !proc_strobe && cyc.burst_advance_n) |=>
            (array_req.addr == $past(array_req.addr)))
        else $error("suspend moved the address");

    cs_first_ignore_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (cyc.chip_select_low_first && cyc.controller_addr_strobe_n && !burst_live) |=>
            (!array_req.read && !array_req.write))
        else $error("processor strobe not ignored");

    sleep_entry_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (state == BSC_ST_ACTIVE && sleep_sync) ##1 sleep_sync[*2] |=> (state == BSC_ST_ASLEEP))
        else $error("sleep entry not two cycles");

    sleep_exit_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (state == BSC_ST_ASLEEP && !sleep_sync) ##1 (!sleep_sync)[*2] |=> (state == BSC_ST_ACTIVE))
        else $error("sleep exit not two cycles");

    sleep_quiet_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (state != BSC_ST_ACTIVE) |=> (!array_req.write && !array_req.read))
        else $error("access during sleep");

    sleep_float_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        sleep_level |-> !dq_oe)
        else $error("data driven while sleeping");

    write_float_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        array_req.write |-> !dq_oe)
        else $error("data driven during write");

    oe_gate_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (array_req.read && output_enable_n) |-> !dq_oe)
        else $error("output enable ignored");

    oe_read_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (array_req.read && !output_enable_n && !sleep_level) |-> dq_oe)
        else $error("read data not driven");

    sleep_block_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        sleep_level |=> (!array_req.read && !array_req.write))
        else $error("access taken while sleep raised");

    cont_step_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (accept && burst_live && !proc_strobe && cyc.controller_addr_strobe_n && !cyc.burst_advance_n) |=>
            (array_req.addr[BSC_LSB_W-1:0] != $past(array_req.addr[BSC_LSB_W-1:0])))
        else $error("continue did not step the burst");

    ctrl_read_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (accept && cyc.processor_addr_strobe_n && !cyc.controller_addr_strobe_n && chips_ok && !write_req) |=>
            (array_req.read && !array_req.write && array_req.addr == $past(addr)))
        else $error("controller read begin missed");

    global_all_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (accept && burst_live && !proc_strobe && cyc.controller_addr_strobe_n && !wctl.global_write_n) |=>
            (array_req.write && array_req.byte_en == 4'hf))
        else $error("global write missed a lane");

    burst_end_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (accept && deselect) ##1 (accept && !proc_strobe && cyc.controller_addr_strobe_n) |=>
            (!array_req.read && !array_req.write))
        else $error("burst went on after deselect");

endmodule

/* hdl/bsc_wr_decode.sv */
// byte write decode of the write control inputs
module bsc_wr_decode
    import bsc_pkg::*;
(
    input  wire bsc_write_ctl_t       wctl,
    output logic [BSC_LANES-1:0]      byte_en,
    output logic                      write_req
);

    // ==========================================================
    // per lane enable: global write overrides the byte enables
    for (genvar i = 0; i < BSC_LANES; i++)
    begin : g_lane
        assign byte_en[i] = ~wctl.global_write_n |
                            (~wctl.byte_write_enable_n & ~wctl.byte_lane_select_n[i]);
    end

    // all lanes off, or byte enable and global write both high, reads
    assign write_req = |byte_en;

endmodule
